//--- src/phrs_consts.vh
/*
  Constants of the controller handshake and recipe select block.
  Assumes the includer sits on a 100 MHz clock.
*/
`ifndef PHRS_CONSTS_VH
`define PHRS_CONSTS_VH

`define PHRS_CLK_HZ      100000000
`define PHRS_BAUD        2400
`define PHRS_DATA_BITS   8
`define PHRS_DEB_MS      10
`define PHRS_MUX_MS      100
`define PHRS_FORCE_MS    2000

// operating modes
`define PHRS_MODE_LOCAL  2'h0
`define PHRS_MODE_REMOTE 2'h1
`define PHRS_MODE_COMP   2'h2

// characters on the serial link
`define PHRS_CH_EOF      8'h1a
`define PHRS_CH_A        8'h61
`define PHRS_CH_I        8'h69
`define PHRS_CH_R        8'h72
`define PHRS_CH_S        8'h73
`define PHRS_CH_COMMA    8'h2c
`define PHRS_CH_ZERO     8'h30
`define PHRS_CH_NINE     8'h39

// message kinds
`define PHRS_MSG_RES     2'h0
`define PHRS_MSG_ID      2'h1
`define PHRS_MSG_STAT    2'h2

`define PHRS_RES_LAST    5'h1f
`define PHRS_FORCE_LAST  3'h4
`define PHRS_RST_VAL     16'h0000

`endif

//--- src/phrs_top.v
/*
  Controller handshake, recipe select, held analog outputs and the
  2400 baud serial port of the analyzer, plus the byte FIFO in front
  of the transmitter.
  Assumes: contact inputs are asynchronous (1 = closed), the analysis
  engine and analog converters run on clk.
*/
// How it works
// R1: idle holds ready contact closed
// R2: controller closes start while ready is shown
// R3: start closure begins analysis, opens ready, default recipe without select
// R4: controller waits for ready to close again
// R5: outputs and serial results updated before ready returns
// R6: ready closes after outputs are updated
// R7: controller reads outputs only after ready closes
// R8: back to idle with ready closed, next start accepted
// R9: controller sets recipe contacts before closing start
// R10: recipe contacts decode as binary index, weights 1, 2, 4
// R11: settings table maps contact index to stored recipe
// R12: under controller handshaking only start contact starts analysis
// R13: serial link 2400 baud, 8 data bits, no parity, 1 stop
// R14: local or remote mode sends new results unprompted
// R15: computer mode sends results only on request
// R16: analog values load at completion and hold until next
// R17: four physical outputs, each also carries logical output plus four
// R18: forcing sequence steps outputs through preset values
// R19: lower case commands a,XX i r s
// R20: every response ends with end-of-file code 26
// R21: contacts synchronised, debounced, recipe sampled at start acceptance
// R22: start ignored while analysis runs
`timescale 1ns/10ps
`default_nettype none
`include "phrs_consts.vh"

// ==========================================================
// byte FIFO
module phrs_fifo #(
  parameter W  = 8,
  parameter AW = 4
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW:0]  wp_r;
  reg [AW:0]  rp_r;
  wire        full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire        empty = (wp_r == rp_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_r[AW-1:0]];
  always @(posedge clk) begin
    if (in_valid && !full)
      mem[wp_r[AW-1:0]] <= in_data;
  end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wp_r <= wp_r + 1'b1;
      if (out_ready && !empty)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule // phrs_fifo

// ==========================================================
// top
module phrs_top #(
  parameter DW        = 16,
  parameter ID_CHAR   = 8'h41, // arbitrary identity character
  parameter BAUD_CYC  = `PHRS_CLK_HZ / `PHRS_BAUD,
  parameter DEB_CYC   = `PHRS_DEB_MS * (`PHRS_CLK_HZ / 1000),
  parameter MUX_CYC   = `PHRS_MUX_MS * (`PHRS_CLK_HZ / 1000),
  parameter FORCE_CYC = `PHRS_FORCE_MS * (`PHRS_CLK_HZ / 1000)
) (
  input  wire          clk,
  input  wire          rstn,
  input  wire          start_in,
  input  wire [2:0]    rsel_in,
  input  wire          plc_mode,
  input  wire          rsel_en,
  input  wire [6:0]    default_recipe,
  input  wire [23:0]   recipe_map,
  input  wire [1:0]    op_mode,
  input  wire          force_en,
  input  wire          force_current,
  input  wire          anl_done,
  input  wire          anl_wr,
  input  wire [2:0]    anl_idx,
  input  wire [DW-1:0] anl_val,
  input  wire          rxd,
  output reg           ready_r,
  output reg           anl_start_r,
  output reg  [6:0]    run_recipe_r,
  output reg  [DW-1:0] aout0_r,
  output reg  [DW-1:0] aout1_r,
  output reg  [DW-1:0] aout2_r,
  output reg  [DW-1:0] aout3_r,
  output reg           aout_bank_r,
  output reg           txd_r,
  output reg  [1:0]    state_r
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_SEND = 2'h2;
  localparam ST_DONE = 2'h3;

  function [31:0] cnt_of;  // cycle count, at least one
    input integer c;
    cnt_of = (c < 1) ? 32'h1 : c;
  endfunction

  function [7:0] hex_ch;
    input [3:0] n;
    hex_ch = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
  endfunction

  function [DW-1:0] force_val;  // preset forcing values
    input [2:0] step;
    input       cur;
    reg   [DW-1:0] full;
    begin
      full = {DW{1'b1}};
      // current mode starts at the live zero, 4 of 20
      if (cur)
        force_val = (full / 5) + ((full - full / 5) / 4) * step;
      else
        force_val = (full / 4) * step;
    end
  endfunction

  // ==========================================================
  // contact synchronisers and debounce
  reg  [3:0]  c_s1_r;
  reg  [3:0]  c_s2_r;
  reg  [3:0]  c_db_r;
  reg  [31:0] db_cnt_r;
  reg         start_prev_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      c_s1_r       <= 4'h0;
      c_s2_r       <= 4'h0;
      c_db_r       <= 4'h0;
      db_cnt_r     <= 32'h0;
      start_prev_r <= 1'b0;
    end else begin
      c_s1_r       <= {start_in, rsel_in};                      // [R21]
      c_s2_r       <= c_s1_r;
      start_prev_r <= c_db_r[3];
      if (c_s2_r == c_db_r)
        db_cnt_r <= 32'h0;
      else if (db_cnt_r >= cnt_of(DEB_CYC) - 1) begin
        c_db_r   <= c_s2_r;                                     // [R21]
        db_cnt_r <= 32'h0;
      end else
        db_cnt_r <= db_cnt_r + 32'h1;
    end
  end
  wire       start_edge = c_db_r[3] && !start_prev_r;
  wire [2:0] rsel_idx   = c_db_r[2:0];                          // [R10]
  wire [2:0] mapped     = recipe_map[rsel_idx*3 +: 3];          // [R11]

  // ==========================================================
  // serial receiver
  reg  [1:0]  rx_s_r;
  reg  [31:0] rx_cnt_r;
  reg  [3:0]  rx_bit_r;
  reg  [7:0]  rx_sh_r;
  reg         rx_busy_r;
  reg         rx_stb_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_s_r    <= 2'h3;
      rx_cnt_r  <= 32'h0;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
      rx_busy_r <= 1'b0;
      rx_stb_r  <= 1'b0;
    end else begin
      rx_s_r   <= {rx_s_r[0], rxd};
      rx_stb_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_s_r[1]) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= cnt_of(BAUD_CYC / 2);
          rx_bit_r  <= 4'h0;
        end
      end else if (rx_cnt_r != 32'h0)
        rx_cnt_r <= rx_cnt_r - 32'h1;
      else begin
        rx_cnt_r <= cnt_of(BAUD_CYC) - 32'h1;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0) begin
          if (rx_s_r[1])
            rx_busy_r <= 1'b0;  // glitch, not a start bit
        end else if (rx_bit_r <= `PHRS_DATA_BITS)            // [R13]
          rx_sh_r <= {rx_s_r[1], rx_sh_r[7:1]};
        else begin
          rx_busy_r <= 1'b0;
          rx_stb_r  <= rx_s_r[1];  // bad stop bit drops the byte
        end
      end
    end
  end

  // ==========================================================
  // command parser: a,XX i r s
  reg  [1:0] ps_r;
  reg  [3:0] tens_r;
  reg        ser_go_r;
  reg  [6:0] ser_rcp_r;
  reg        req_r;
  reg  [1:0] req_kind_r;
  reg        gen_busy_r;
  reg        auto_r;
  wire       gen_take = !gen_busy_r && (auto_r || req_r);
  wire       is_dig = (rx_sh_r >= `PHRS_CH_ZERO) && (rx_sh_r <= `PHRS_CH_NINE);
  wire [3:0] dig    = rx_sh_r[3:0];
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ps_r       <= 2'h0;
      tens_r     <= 4'h0;
      ser_go_r   <= 1'b0;
      ser_rcp_r  <= 7'h00;
      req_r      <= 1'b0;
      req_kind_r <= `PHRS_MSG_RES;
    end else begin
      ser_go_r <= 1'b0;
      if (req_r && gen_take && !auto_r)
        req_r <= 1'b0;
      if (rx_stb_r) begin
        ps_r <= 2'h0;
        case (ps_r)
          2'h1: ps_r <= (rx_sh_r == `PHRS_CH_COMMA) ? 2'h2 : 2'h0;
          2'h2: begin
            tens_r <= dig;
            ps_r   <= is_dig ? 2'h3 : 2'h0;
          end
          2'h3: begin
            if (is_dig) begin
              ser_go_r  <= 1'b1;                                // [R19]
              ser_rcp_r <= tens_r * 7'd10 + {3'h0, dig};
            end
          end
          default: begin
            if (rx_sh_r == `PHRS_CH_A)                          // [R19]
              ps_r <= 2'h1;
            else if (rx_sh_r == `PHRS_CH_I || rx_sh_r == `PHRS_CH_R ||
                     rx_sh_r == `PHRS_CH_S) begin
              req_r      <= 1'b1;                               // [R15]
              req_kind_r <= (rx_sh_r == `PHRS_CH_I) ? `PHRS_MSG_ID :
                            (rx_sh_r == `PHRS_CH_R) ? `PHRS_MSG_RES :
                                                      `PHRS_MSG_STAT;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // message generator into the FIFO
  reg  [1:0] gen_kind_r;
  reg  [4:0] gen_idx_r;
  reg        gen_eof_r;
  reg  [DW-1:0] hold_r [0:7];
  wire       f_in_ready;
  reg  [7:0] gen_byte;
  wire [DW-1:0] res_sh = hold_r[gen_idx_r[4:2]] >> {~gen_idx_r[1:0], 2'h0};
  always @* begin
    gen_byte = `PHRS_CH_EOF;                                    // [R20]
    if (!gen_eof_r) begin
      case (gen_kind_r)
        `PHRS_MSG_RES:
          gen_byte = hex_ch(res_sh[3:0]);
        `PHRS_MSG_ID:   gen_byte = ID_CHAR;
        default: gen_byte = `PHRS_CH_ZERO + {6'h00, state_r};
      endcase
    end
  end
  wire gen_last_data = (gen_kind_r != `PHRS_MSG_RES) ||
                       (gen_idx_r == `PHRS_RES_LAST);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gen_busy_r <= 1'b0;
      gen_kind_r <= `PHRS_MSG_RES;
      gen_idx_r  <= 5'h00;
      gen_eof_r  <= 1'b0;
    end else if (gen_take) begin
      gen_busy_r <= 1'b1;
      gen_kind_r <= auto_r ? `PHRS_MSG_RES : req_kind_r;
      gen_idx_r  <= 5'h00;
      gen_eof_r  <= 1'b0;
    end else if (gen_busy_r && f_in_ready) begin
      // stalls while the FIFO is full
      if (gen_eof_r)
        gen_busy_r <= 1'b0;
      else if (gen_last_data)
        gen_eof_r <= 1'b1;
      else
        gen_idx_r <= gen_idx_r + 5'h01;
    end
  end

  wire [7:0] f_out;
  wire       f_out_valid;
  reg        tx_busy_r;
  phrs_fifo #(.W(8), .AW(4)) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_data   (gen_byte),
    .in_valid  (gen_busy_r),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_out_valid),
    .out_ready (!tx_busy_r)
  );

  // ==========================================================
  // serial transmitter, 8N1
  reg  [31:0] tx_cnt_r;
  reg  [9:0]  tx_sh_r;
  reg  [3:0]  tx_bit_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_busy_r <= 1'b0;
      tx_cnt_r  <= 32'h0;
      tx_sh_r   <= 10'h3ff;
      tx_bit_r  <= 4'h0;
      txd_r     <= 1'b1;
    end else if (!tx_busy_r) begin
      txd_r <= 1'b1;
      if (f_out_valid) begin
        tx_busy_r <= 1'b1;
        tx_sh_r   <= {1'b1, f_out, 1'b0};                       // [R13]
        tx_bit_r  <= 4'h0;
        tx_cnt_r  <= 32'h0;
      end
    end else if (tx_cnt_r != 32'h0)
      tx_cnt_r <= tx_cnt_r - 32'h1;
    else if (tx_bit_r == `PHRS_DATA_BITS + 2)
      tx_busy_r <= 1'b0;
    else begin
      txd_r    <= tx_sh_r[0];
      tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
      tx_bit_r <= tx_bit_r + 4'h1;
      tx_cnt_r <= cnt_of(BAUD_CYC) - 32'h1;
    end
  end

  // ==========================================================
  // handshake sequence
  reg  [DW-1:0] shadow_r [0:7];
  wire auto_mode = (op_mode == `PHRS_MODE_LOCAL) || (op_mode == `PHRS_MODE_REMOTE);
  wire go_plc    = plc_mode && start_edge;                      // [R12]
  wire go_ser    = !plc_mode && ser_go_r;
  integer i;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r      <= ST_IDLE;
      ready_r      <= 1'b1;
      anl_start_r  <= 1'b0;
      run_recipe_r <= 7'h00;
      auto_r       <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        shadow_r[i] <= `PHRS_RST_VAL;
        hold_r[i]   <= `PHRS_RST_VAL;
      end
    end else begin
      anl_start_r <= 1'b0;
      if (gen_take)
        auto_r <= 1'b0;
      if (anl_wr)
        shadow_r[anl_idx] <= anl_val;
      case (state_r)
        ST_IDLE: begin
          ready_r <= 1'b1;                                      // [R1] [R8]
          if (go_plc || go_ser) begin
            anl_start_r  <= 1'b1;                               // [R3]
            ready_r      <= 1'b0;                               // [R3]
            state_r      <= ST_RUN;
            if (go_ser)
              run_recipe_r <= ser_rcp_r;
            else if (rsel_en)
              run_recipe_r <= {4'h0, mapped};                   // [R21]
            else
              run_recipe_r <= default_recipe;                   // [R3]
          end
        end
        ST_RUN: begin
          ready_r <= 1'b0;                                      // [R22]
          if (anl_done) begin
            for (i = 0; i < 8; i = i + 1)
              hold_r[i] <= shadow_r[i];                         // [R16] [R5]
            auto_r  <= auto_mode;                               // [R14]
            state_r <= auto_mode ? ST_SEND : ST_DONE;
          end
        end
        ST_SEND: begin
          // ready waits until the last result byte has gone into the FIFO
          if (!auto_r && !gen_busy_r)
            state_r <= ST_DONE;                                 // [R5]
        end
        default: begin
          ready_r <= 1'b1;                                      // [R6]
          state_r <= ST_IDLE;                                   // [R8]
        end
      endcase
    end
  end

  // ==========================================================
  // analog outputs: bank multiplex and forcing sequence
  reg  [31:0] mux_cnt_r;
  reg  [31:0] frc_cnt_r;
  reg  [2:0]  frc_step_r;
  wire [DW-1:0] fv = force_val(frc_step_r, force_current);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mux_cnt_r   <= 32'h0;
      frc_cnt_r   <= 32'h0;
      frc_step_r  <= 3'h0;
      aout_bank_r <= 1'b0;
      aout0_r     <= `PHRS_RST_VAL;
      aout1_r     <= `PHRS_RST_VAL;
      aout2_r     <= `PHRS_RST_VAL;
      aout3_r     <= `PHRS_RST_VAL;
    end else begin
      if (mux_cnt_r >= cnt_of(MUX_CYC) - 1) begin
        mux_cnt_r   <= 32'h0;
        aout_bank_r <= !aout_bank_r;                            // [R17]
      end else
        mux_cnt_r <= mux_cnt_r + 32'h1;
      if (!force_en) begin
        frc_cnt_r  <= 32'h0;
        frc_step_r <= 3'h0;
      end else if (frc_cnt_r >= cnt_of(FORCE_CYC) - 1) begin
        frc_cnt_r  <= 32'h0;
        frc_step_r <= (frc_step_r == `PHRS_FORCE_LAST) ? 3'h0 :
                      frc_step_r + 3'h1;                        // [R18]
      end else
        frc_cnt_r <= frc_cnt_r + 32'h1;
      if (force_en) begin
        aout0_r <= fv;                                          // [R18]
        aout1_r <= fv;
        aout2_r <= fv;
        aout3_r <= fv;
      end else begin
        // bank 1 shows logical outputs 5 to 8
        aout0_r <= hold_r[{aout_bank_r, 2'h0}];                 // [R17] [R16]
        aout1_r <= hold_r[{aout_bank_r, 2'h1}];
        aout2_r <= hold_r[{aout_bank_r, 2'h2}];
        aout3_r <= hold_r[{aout_bank_r, 2'h3}];
      end
    end
  end
endmodule // phrs_top

`default_nettype wire

//--- testbench/phrs_top_assertions.sv
/*
  Port checker for the handshake and recipe select block.
  Assumes it is bound onto phrs_top and gets DW and BAUD_CYC from it.
*/
`timescale 1ns/10ps
`default_nettype none
module phrs_top_assertions #(
  parameter DW       = 16,
  parameter BAUD_CYC = 8
) (
  input wire logic          clk,
  input wire logic          rstn,
  input wire logic          start_in,
  input wire logic          plc_mode,
  input wire logic [1:0]    op_mode,
  input wire logic          force_en,
  input wire logic          anl_done,
  input wire logic          ready_r,
  input wire logic          anl_start_r,
  input wire logic [6:0]    run_recipe_r,
  input wire logic [DW-1:0] aout0_r,
  input wire logic [DW-1:0] aout1_r,
  input wire logic [DW-1:0] aout2_r,
  input wire logic [DW-1:0] aout3_r,
  input wire logic          aout_bank_r,
  input wire logic          txd_r,
  input wire logic [1:0]    state_r
);
  // ==========================================================
  // line idle time; a byte of ones stays high for under 12 bits
  logic [15:0] idle_cnt_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) idle_cnt_r <= 16'h0000;
    else if (!txd_r) idle_cnt_r <= 16'h0000;
    else if (idle_cnt_r != 16'hffff) idle_cnt_r <= idle_cnt_r + 16'h0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // properties
  a_start_opens_ready: assert property (anl_start_r |-> !ready_r)
    else $error("ready still closed at start");
  a_start_one_cycle: assert property (anl_start_r |=> !anl_start_r)
    else $error("start pulse longer than one cycle");
  a_start_from_idle: assert property (anl_start_r |->
    $past(ready_r) && $past(state_r) == 2'h0)
    else $error("start accepted outside idle");
  a_start_needs_contact: assert property (
    anl_start_r && plc_mode |-> $past(start_in, 3))
    else $error("start without closed start contact");
  a_idle_ready: assert property (state_r == 2'h0 |-> ready_r)
    else $error("ready open while idle");
  a_run_not_ready: assert property (state_r == 2'h1 |-> !ready_r)
    else $error("ready closed during analysis");
  a_done_ready_late: assert property (
    anl_done && state_r == 2'h1 && op_mode[1] |=> !ready_r ##1 ready_r)
    else $error("ready not closed two cycles after completion");
  a_aout_held: assert property (
    !force_en && !$past(force_en) && !$past(force_en, 2) &&
    !$past(anl_done) && !$past(anl_done, 2) && !$past(anl_done, 3) &&
    aout_bank_r == $past(aout_bank_r) && aout_bank_r == $past(aout_bank_r, 2)
    |-> $stable(aout0_r) && $stable(aout1_r) && $stable(aout2_r) &&
        $stable(aout3_r))
    else $error("analog output changed between completions");
  a_recipe_kept: assert property (
    state_r != 2'h0 && $past(state_r) != 2'h0 |-> $stable(run_recipe_r))
    else $error("recipe changed during a run");
  a_comp_silent: assert property (
    anl_done && op_mode[1] && idle_cnt_r > 12 * BAUD_CYC |=> txd_r [*8])
    else $error("unsolicited transmit in computer mode");
  a_auto_sends: assert property (
    anl_done && !op_mode[1] && state_r == 2'h1 |-> ##[1:200] !txd_r)
    else $error("no automatic result transmit");
endmodule // phrs_top_assertions

bind phrs_top phrs_top_assertions #(.DW(DW), .BAUD_CYC(BAUD_CYC)) u_chk (
  .clk(clk), .rstn(rstn), .start_in(start_in), .plc_mode(plc_mode),
  .op_mode(op_mode), .force_en(force_en), .anl_done(anl_done),
  .ready_r(ready_r), .anl_start_r(anl_start_r),
  .run_recipe_r(run_recipe_r), .aout0_r(aout0_r), .aout1_r(aout1_r),
  .aout2_r(aout2_r), .aout3_r(aout3_r), .aout_bank_r(aout_bank_r),
  .txd_r(txd_r), .state_r(state_r));
`default_nettype wire

//--- testbench/phrs_plc_model.sv
/*
  Controller model: start and recipe contacts plus a serial terminal.
  Assumes contacts read 1 when closed and drives on the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module phrs_plc_model #(
  parameter BAUD_CYC = 8
) (
  input  wire logic       clk,
  input  wire logic       ready_in,
  input  wire logic       txd_in,
  output var  logic       start_out,
  output var  logic [2:0] rsel_out,
  output var  logic       rxd_out
);
  initial begin
    start_out = 1'b0;
    rsel_out = 3'h0;
    rxd_out = 1'b1;
  end

  // ==========================================================
  // contacts
  task automatic wait_ready(input logic lvl, input int lim, output bit ok);
    int n;
    n = 0;
    while (ready_in !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    ok = (ready_in === lvl);
  endtask

  task automatic request(input logic [2:0] sel, output bit ok);
    wait_ready(1'b1, 2000, ok);
    @(negedge clk);
    rsel_out = sel;
    repeat (2) @(negedge clk);
    start_out = 1'b1;
    if (ok) wait_ready(1'b0, 40, ok);
    start_out = 1'b0;
  endtask

  // closes start while busy; the block must ignore it
  task automatic poke();
    @(negedge clk);
    start_out = 1'b1;
    repeat (20) @(negedge clk);
    start_out = 1'b0;
    repeat (20) @(negedge clk);
  endtask

  // ==========================================================
  // serial terminal
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    int         i;
    f = {1'b1, b, 1'b0};
    for (i = 0; i < 10; i++) begin
      @(negedge clk);
      rxd_out = f[i];
      repeat (BAUD_CYC - 1) @(negedge clk);
    end
  endtask

  task automatic recv_byte(output logic [7:0] b, output bit ok);
    int n;
    int i;
    n = 0;
    while (txd_in !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    repeat (BAUD_CYC / 2) @(negedge clk);
    for (i = 0; i < 8; i++) begin
      repeat (BAUD_CYC) @(negedge clk);
      b[i] = txd_in;
    end
    repeat (BAUD_CYC) @(negedge clk);
    ok = (n < 4000) && (txd_in === 1'b1);
  endtask
endmodule // phrs_plc_model
`default_nettype wire

//--- testbench/tb_top.sv
/*
  Self-checking bench for phrs_top with shortened counts.
  Assumes the controller model drives contacts and serial input.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module tb_top;
  localparam int         BC   = 8;
  localparam logic [7:0] ID_C = 8'h5a; // arbitrary identity value
  logic        clk, rstn, plc_mode, rsel_en, anl_done, anl_wr, start_in;
  logic        rxd, ready_r, anl_start_r, aout_bank_r, txd_r;
  logic        force_en, force_current;
  logic [2:0]  rsel_in, anl_idx;
  logic [1:0]  op_mode, state_r;
  logic [6:0]  default_recipe, run_recipe_r;
  logic [23:0] recipe_map;
  logic [15:0] anl_val, aout0_r, aout1_r, aout2_r, aout3_r;
  logic [15:0] nxt [8];
  logic [15:0] chv [8];
  int          n_errors = 0;
  int          num_checks = 0;
  int          n_starts = 0;

  phrs_top #(.ID_CHAR(ID_C), .BAUD_CYC(BC), .DEB_CYC(4), .MUX_CYC(16),
    .FORCE_CYC(16)) dut (.clk(clk), .rstn(rstn), .start_in(start_in),
    .rsel_in(rsel_in), .plc_mode(plc_mode), .rsel_en(rsel_en),
    .default_recipe(default_recipe), .recipe_map(recipe_map),
    .op_mode(op_mode), .force_en(force_en), .force_current(force_current),
    .anl_done(anl_done), .anl_wr(anl_wr), .anl_idx(anl_idx),
    .anl_val(anl_val), .rxd(rxd), .ready_r(ready_r),
    .anl_start_r(anl_start_r), .run_recipe_r(run_recipe_r),
    .aout0_r(aout0_r), .aout1_r(aout1_r), .aout2_r(aout2_r),
    .aout3_r(aout3_r), .aout_bank_r(aout_bank_r), .txd_r(txd_r),
    .state_r(state_r));

  phrs_plc_model #(.BAUD_CYC(BC)) plc (.clk(clk), .ready_in(ready_r),
    .txd_in(txd_r), .start_out(start_in), .rsel_out(rsel_in),
    .rxd_out(rxd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (anl_start_r === 1'b1) n_starts++;

  // ==========================================================
  // helpers
  function automatic logic [7:0] hexc(input logic [3:0] d);
    return (d < 4'ha) ? 8'h30 + d : 8'h57 + d;
  endfunction

  task automatic write_all(input logic [15:0] base);
    int i;
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      nxt[i] = base + 16'(i * 4369);
      anl_wr = 1'b1;
      anl_idx = 3'(i);
      anl_val = nxt[i];
    end
    @(negedge clk);
    anl_wr = 1'b0;
  endtask

  task automatic measure(input logic [2:0] sel, input logic [6:0] exp);
    bit ok;
    int s0;
    s0 = n_starts;
    plc.request(sel, ok);
    @(negedge clk);
    `CHK("accept", 1'b1, ok)
    `CHK("recipe", exp, run_recipe_r)
    `CHK("starts", s0 + 1, n_starts)
  endtask

  task automatic complete(input int lim);
    bit ok;
    @(negedge clk);
    anl_done = 1'b1;
    chv = nxt;
    @(negedge clk);
    anl_done = 1'b0;
    plc.wait_ready(1'b1, lim, ok);
    `CHK("ready", 1'b1, ready_r)
  endtask

  // samples only when the bank has settled
  task automatic check_aout(input string nm);
    logic b;
    b = ~aout_bank_r;
    while (b !== aout_bank_r) begin
      b = aout_bank_r;
      repeat (3) @(negedge clk);
    end
    `CHK(nm, chv[{b, 2'b00}], aout0_r)
    `CHK(nm, chv[{b, 2'b01}], aout1_r)
    `CHK(nm, chv[{b, 2'b10}], aout2_r)
    `CHK(nm, chv[{b, 2'b11}], aout3_r)
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial begin
    int         i, k, s0;
    logic [7:0] b, e;
    bit         ok;
    logic [7:0] cmd [2] = '{8'h69, 8'h73};
    logic [7:0] rsp [2] = '{ID_C, 8'h30};
    {rstn, rsel_en, anl_done, anl_wr, anl_idx, anl_val} = 23'h0;
    {force_en, force_current} = 2'h0;
    plc_mode = 1'b1;
    op_mode = 2'h2;
    default_recipe = 7'h2a;
    recipe_map = 24'h5397ac;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    `CHK("rst_ready", 1'b1, ready_r)
    `CHK("rst_txd", 1'b1, txd_r)
    `CHK("rst_state", 2'h0, state_r)
    write_all(16'h1234);
    measure(3'h5, 7'h2a);
    s0 = n_starts;
    plc.poke();
    `CHK("busy_ready", 1'b0, ready_r)
    `CHK("busy_starts", s0, n_starts)
    complete(20);
    check_aout("aout");
    write_all(16'hbeef);
    repeat (40) @(negedge clk);
    check_aout("hold");
    rsel_en = 1'b1;
    for (k = 0; k < 8; k++) begin
      measure(3'(k), {4'h0, recipe_map[3*k +: 3]});
      complete(20);
    end
    check_aout("aout2");
    for (k = 0; k < 2; k++) begin
      fork
        plc.send_byte(cmd[k]);
        plc.recv_byte(b, ok);
      join
      `CHK("reply", rsp[k], b)
      plc.recv_byte(b, ok);
      `CHK("eof", 8'h1a, b)
      `CHK("stop", 1'b1, ok)
    end
    s0 = n_starts;
    for (k = 0; k < 2; k++) begin
      plc_mode = (k == 0);
      plc.send_byte(8'h61);
      plc.send_byte(8'h2c);
      plc.send_byte(8'h31);
      plc.send_byte(8'h32);
      for (i = 0; i < 40 && ready_r !== 1'b0; i++) @(negedge clk);
      @(negedge clk);
      `CHK("ser_starts", s0 + k, n_starts)
    end
    `CHK("ser_recipe", 7'h0c, run_recipe_r)
    complete(20);
    plc_mode = 1'b1;
    for (k = 0; k < 2; k++) begin
      op_mode = 2'(k);
      write_all(16'h0a5f + 16'(k));
      measure(3'h0, {4'h0, recipe_map[2:0]});
      fork
        complete(4000);
        for (i = 0; i < 33; i++) begin
          plc.recv_byte(b, ok);
          e = (i < 32) ? hexc(4'(nxt[i/4] >> (12 - 4 * (i % 4)))) : 8'h1a;
          `CHK("auto_tx", e, b)
          if (i == 0) `CHK("tx_ready", 1'b0, ready_r)
        end
      join
    end
    {force_current, force_en} = 2'h1;
    repeat (19) @(negedge clk);
    `CHK("force_v", 16'h3fff, aout0_r)
    force_current = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("force_c", 16'h6666, aout3_r)
    force_en = 1'b0;
    check_aout("unforce");
    end_of_test();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
